// ===== shared/acgc_pkg.sv
// Constants and carrier types for the audio clock and pin configuration bank.
// Assumes an 8-bit register port driven by the device's control-port decoder.
package acgc_pkg;
   // Register offsets
   localparam logic [7:0] PIN_DIR_OFFSET     = 8'h08;
   localparam logic [7:0] CLK_DIR_POL_OFFSET = 8'h09;
   localparam logic [7:0] PROC_IN_OFFSET     = 8'h0a;
   localparam logic [7:0] DIV_RELEASE_OFFSET = 8'h0c;

   // Field positions
   localparam int PIN2_OE_BIT      = 5;
   localparam int MUTE_FWD_BIT     = 4;
   localparam int PIN0_OE_BIT      = 3;
   localparam int BCLK_POL_BIT     = 5;
   localparam int BCLK_OE_BIT      = 4;
   localparam int FCLK_OE_BIT      = 0;
   localparam int PROC_IN_BIT      = 7;
   localparam int BCLK_REL_BIT     = 1;
   localparam int FCLK_REL_BIT     = 0;

   // Reset values
   localparam logic [7:0] PIN_DIR_RESET     = 8'h00;
   localparam logic [7:0] CLK_DIR_POL_RESET = 8'h00;
   localparam logic [7:0] PROC_IN_RESET     = 8'h00;
   localparam logic [7:0] DIV_RELEASE_RESET = 8'h01;

   // Default division factors: frame clock = 64 bit clocks per sample
   localparam logic [7:0] BCLK_DIV_RESET = 8'h04;
   localparam logic [7:0] FCLK_DIV_RESET = 8'h40;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acgc_reg_req_type;

   typedef struct packed {
      logic out;
      logic oe_n;
   } acgc_pin_drive_type;
endpackage

// ===== src/acgc_clock_divider.sv
// Divides the system clock into bit clock and frame clock for master mode.
// Assumes division factors are programmed before release and held stable.
`timescale 1ns/1ps
module acgc_clock_divider #(
   parameter int DIV_W = 8
) (
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_reset_n,
   // Control
   input  wire logic             i_bclk_release,
   input  wire logic             i_fclk_release,
   input  wire logic [DIV_W-1:0] i_bclk_div,
   input  wire logic [DIV_W-1:0] i_fclk_div,
   // Generated clocks
   output logic                  o_bclk,
   output logic                  o_bclk_fall,
   output logic                  o_fclk
);
   logic [DIV_W-1:0] bclk_cnt_reg;
   logic [DIV_W-1:0] fclk_cnt_reg;
   logic             bclk_tick;

   // Half-period tick; a factor below 2 behaves as 2
   assign bclk_tick = (bclk_cnt_reg + DIV_W'(1) >= (i_bclk_div >> 1)) || (i_bclk_div < DIV_W'(2));

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bclk_cnt_reg <= '0;
         o_bclk       <= 1'b0;
         o_bclk_fall  <= 1'b0;
      end else if (!i_bclk_release) begin
         bclk_cnt_reg <= '0;
         o_bclk       <= 1'b0;
         o_bclk_fall  <= 1'b0;
      end else if (bclk_tick) begin
         bclk_cnt_reg <= '0;
         o_bclk       <= ~o_bclk;
         o_bclk_fall  <= o_bclk;
      end else begin
         bclk_cnt_reg <= bclk_cnt_reg + DIV_W'(1);
         o_bclk_fall  <= 1'b0;
      end
   end

   // Frame clock toggles every half frame counted in bit-clock falls
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fclk_cnt_reg <= '0;
         o_fclk       <= 1'b0;
      end else if (!i_fclk_release || !i_bclk_release) begin
         fclk_cnt_reg <= '0;
         o_fclk       <= 1'b0;
      end else if (o_bclk_fall) begin
         if (fclk_cnt_reg + DIV_W'(1) >= (i_fclk_div >> 1)) begin
            fclk_cnt_reg <= '0;
            o_fclk       <= ~o_fclk;
         end else begin
            fclk_cnt_reg <= fclk_cnt_reg + DIV_W'(1);
         end
      end
   end
endmodule // acgc_clock_divider

// ===== src/acgc_config_regs.sv
// Audio clock, pin direction and processor input configuration registers.
// Assumes register requests arrive as single-cycle strobes from the control port.
//
// Behaviour
// - Bit 5 sets pin two direction
// - Bit 4 gates mute forwarding to power stage
// - Bit 3 sets pin zero direction
// - Polarity bit selects capture edge of bit clock
// - Bit clock pin driven only in master
// - Master drives clocks; source times data
// - Bit clock is divided master clock
// - Bit 0 sets frame clock pin direction
// - Frame clock divided from bit clock
// - Processor input register drives processor port
// - Reset gives slave, inputs, normal, mute off
`timescale 1ns/1ps
module acgc_config_regs #(
   parameter int DIV_W = 8
) (
   // Clock and reset
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_reset_n,
   // Register port
   input  wire acgc_pkg::acgc_reg_req_type  i_reg_req,
   output logic [7:0]                       o_reg_rdata,
   output logic                             o_reg_rvalid,
   // General pins
   input  wire logic                        i_pin2_in,
   input  wire logic                        i_pin0_in,
   input  wire logic                        i_pin2_out,
   input  wire logic                        i_pin0_out,
   output logic                             o_pin2_out,
   output logic                             o_pin2_oe_n,
   output logic                             o_pin0_out,
   output logic                             o_pin0_oe_n,
   output logic                             o_pin2_sampled,
   output logic                             o_pin0_sampled,
   // Mute path
   input  wire logic                        i_mute_req,
   output logic                             o_mute_power_stage,
   // Serial audio clocks
   input  wire logic                        i_bclk_in,
   input  wire logic                        i_fclk_in,
   input  wire logic                        i_data_in,
   output logic                             o_bclk_out,
   output logic                             o_bclk_oe_n,
   output logic                             o_fclk_out,
   output logic                             o_fclk_oe_n,
   output logic                             o_data_capture,
   output logic                             o_data_bit,
   output logic                             o_frame_bit,
   // Processor input port
   output logic [7:0]                       o_proc_in
);
   logic [7:0]       pin_dir_reg;
   logic [7:0]       clk_dir_pol_reg;
   logic [7:0]       proc_in_reg;
   logic [7:0]       div_release_reg;
   logic [DIV_W-1:0] bclk_div_reg;
   logic [DIV_W-1:0] fclk_div_reg;
   logic             gen_bclk;
   logic             gen_fclk;
   logic             bclk_prev_reg;
   logic             master_bclk;
   logic             active_bclk;
   logic             capture_edge;
   logic [7:0]       rdata_next;

   function automatic logic hit(input acgc_pkg::acgc_reg_req_type req, input logic [7:0] offs);
      hit = req.write && (req.addr == offs);
   endfunction

   // Whole byte is stored so reserved bits read back as written
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_dir_reg <= acgc_pkg::PIN_DIR_RESET;
      end else if (hit(i_reg_req, acgc_pkg::PIN_DIR_OFFSET)) begin
         pin_dir_reg <= i_reg_req.wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         clk_dir_pol_reg <= acgc_pkg::CLK_DIR_POL_RESET;
      end else if (hit(i_reg_req, acgc_pkg::CLK_DIR_POL_OFFSET)) begin
         clk_dir_pol_reg <= i_reg_req.wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         proc_in_reg <= acgc_pkg::PROC_IN_RESET;
      end else if (hit(i_reg_req, acgc_pkg::PROC_IN_OFFSET)) begin
         proc_in_reg <= i_reg_req.wdata;
      end
   end

   // Divider release bits; factors are fixed defaults with no register of their own
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_release_reg <= acgc_pkg::DIV_RELEASE_RESET;
         bclk_div_reg    <= DIV_W'(acgc_pkg::BCLK_DIV_RESET);
         fclk_div_reg    <= DIV_W'(acgc_pkg::FCLK_DIV_RESET);
      end else if (hit(i_reg_req, acgc_pkg::DIV_RELEASE_OFFSET)) begin
         div_release_reg <= i_reg_req.wdata;
      end
   end

   always_comb begin
      case (i_reg_req.addr)
         acgc_pkg::PIN_DIR_OFFSET:     rdata_next = pin_dir_reg;
         acgc_pkg::CLK_DIR_POL_OFFSET: rdata_next = clk_dir_pol_reg;
         acgc_pkg::PROC_IN_OFFSET:     rdata_next = proc_in_reg;
         acgc_pkg::DIV_RELEASE_OFFSET: rdata_next = div_release_reg;
         default:                      rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata  <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_req.read;
         if (i_reg_req.read) begin
            o_reg_rdata <= rdata_next;
         end
      end
   end

   // General-purpose pins; enable low means driving
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pin2_out     <= 1'b0;
         o_pin2_oe_n    <= 1'b1;
         o_pin0_out     <= 1'b0;
         o_pin0_oe_n    <= 1'b1;
         o_pin2_sampled <= 1'b0;
         o_pin0_sampled <= 1'b0;
      end else begin
         o_pin2_out     <= i_pin2_out;
         o_pin2_oe_n    <= ~pin_dir_reg[acgc_pkg::PIN2_OE_BIT];
         o_pin0_out     <= i_pin0_out;
         o_pin0_oe_n    <= ~pin_dir_reg[acgc_pkg::PIN0_OE_BIT];
         o_pin2_sampled <= i_pin2_in;
         o_pin0_sampled <= i_pin0_in;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_mute_power_stage <= 1'b0;
      end else begin
         o_mute_power_stage <= i_mute_req && pin_dir_reg[acgc_pkg::MUTE_FWD_BIT];
      end
   end

   acgc_clock_divider #(
      .DIV_W (DIV_W)
   ) u_divider (
      .i_clk_sys      (i_clk_sys),
      .i_reset_n      (i_reset_n),
      .i_bclk_release (div_release_reg[acgc_pkg::BCLK_REL_BIT]),
      .i_fclk_release (div_release_reg[acgc_pkg::FCLK_REL_BIT]),
      .i_bclk_div     (bclk_div_reg),
      .i_fclk_div     (fclk_div_reg),
      .o_bclk         (gen_bclk),
      .o_bclk_fall    (),
      .o_fclk         (gen_fclk)
   );

   // Clock pins: bit clock driven only in master mode, frame clock whenever bit 0 is set
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_bclk_out  <= 1'b0;
         o_bclk_oe_n <= 1'b1;
         o_fclk_out  <= 1'b0;
         o_fclk_oe_n <= 1'b1;
      end else begin
         o_bclk_out  <= gen_bclk;
         o_bclk_oe_n <= ~clk_dir_pol_reg[acgc_pkg::BCLK_OE_BIT];
         o_fclk_out  <= gen_fclk;
         o_fclk_oe_n <= ~clk_dir_pol_reg[acgc_pkg::FCLK_OE_BIT];
      end
   end

   // Capture uses the edge opposite the one data changes on
   assign master_bclk  = clk_dir_pol_reg[acgc_pkg::BCLK_OE_BIT];
   assign active_bclk  = master_bclk ? o_bclk_out : i_bclk_in;
   assign capture_edge = clk_dir_pol_reg[acgc_pkg::BCLK_POL_BIT] ? (bclk_prev_reg && !active_bclk)
                                                                 : (!bclk_prev_reg && active_bclk);

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bclk_prev_reg  <= 1'b0;
         o_data_capture <= 1'b0;
         o_data_bit     <= 1'b0;
         o_frame_bit    <= 1'b0;
      end else begin
         bclk_prev_reg  <= active_bclk;
         o_data_capture <= capture_edge;
         if (capture_edge) begin
            o_data_bit  <= i_data_in;
            o_frame_bit <= master_bclk ? o_fclk_out : i_fclk_in;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_proc_in <= 8'h00;
      end else begin
         o_proc_in <= proc_in_reg;
      end
   end
endmodule // acgc_config_regs

// ===== tb/acgc_audio_source.sv
// Serial audio source model driving the slave-mode link inputs.
// Assumes the bench pulses i_go to send one burst of sixteen bit clocks.
`timescale 1ns/1ps
module acgc_audio_source (
   // Clock and control
   input  wire logic i_clk_sys,
   input  wire logic i_go,
   input  wire logic i_inv,
   // Serial link
   output logic      o_bclk,
   output logic      o_fclk,
   output logic      o_data
);
   logic [7:0] cnt_reg = 8'h00;
   logic       fclk_reg = 1'b0;
   logic       data_reg = 1'b0;
   wire        launch = (cnt_reg[2:0] == (i_inv ? 3'h0 : 3'h4)) && (cnt_reg != 8'h00);
   // Bit clock stands low between bursts
   assign o_bclk = cnt_reg[2];
   assign o_fclk = fclk_reg;
   assign o_data = data_reg;
   always_ff @(posedge i_clk_sys) begin
      if (i_go)
         cnt_reg <= 8'h80;
      else if (cnt_reg != 8'h00)
         cnt_reg <= cnt_reg - 8'h01;
   end
   // Idle data toggles so no stale level passes for valid
   always_ff @(posedge i_clk_sys) begin
      if (cnt_reg == 8'h00)
         data_reg <= ~data_reg;
      else if (launch) begin
         data_reg <= cnt_reg[4] ^ cnt_reg[6];
         fclk_reg <= cnt_reg[6];
      end
   end
endmodule // acgc_audio_source

// ===== tb/acgc_checker.sv
// Property checker for the configuration register bank, bound to its top module.
// Assumes single-cycle request strobes and the two-edge write latency of the bank.
`timescale 1ns/1ps
module acgc_checker (
   // Clock and reset
   input wire logic                       i_clk_sys,
   input wire logic                       i_reset_n,
   // Register port
   input wire acgc_pkg::acgc_reg_req_type i_reg_req,
   input wire logic [7:0]                 o_reg_rdata,
   input wire logic                       o_reg_rvalid,
   // Pins, mute and processor port
   input wire logic                       o_pin2_oe_n,
   input wire logic                       o_pin0_oe_n,
   input wire logic                       i_mute_req,
   input wire logic                       o_mute_power_stage,
   input wire logic                       o_bclk_oe_n,
   input wire logic                       o_fclk_oe_n,
   input wire logic [7:0]                 o_proc_in
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   wire  w08 = i_reg_req.write && (i_reg_req.addr == acgc_pkg::PIN_DIR_OFFSET);
   wire  w09 = i_reg_req.write && (i_reg_req.addr == acgc_pkg::CLK_DIR_POL_OFFSET);
   wire  w0a = i_reg_req.write && (i_reg_req.addr == acgc_pkg::PROC_IN_OFFSET);
   logic mute_en_reg;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n)
         mute_en_reg <= 1'b0;
      else if (w08)
         mute_en_reg <= i_reg_req.wdata[4];
   end
   a_read_answer: assert property (i_reg_req.read |=> o_reg_rvalid)
      else $error("read strobe got no answer");
   a_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_req.read))
      else $error("answer without a read");
   a_rdata_hold: assert property (!$past(i_reg_req.read) |-> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   a_pin2_dir: assert property (w08 |-> ##2 (o_pin2_oe_n == !$past(i_reg_req.wdata[5], 2)))
      else $error("pin two direction wrong");
   a_pin0_dir: assert property (w08 |-> ##2 (o_pin0_oe_n == !$past(i_reg_req.wdata[3], 2)))
      else $error("pin zero direction wrong");
   a_mute_gate: assert property (o_mute_power_stage == ($past(i_mute_req) && $past(mute_en_reg)))
      else $error("mute forwarding wrong");
   a_bclk_dir: assert property (w09 |-> ##2 (o_bclk_oe_n == !$past(i_reg_req.wdata[4], 2)))
      else $error("bit clock direction wrong");
   a_fclk_dir: assert property (w09 |-> ##2 (o_fclk_oe_n == !$past(i_reg_req.wdata[0], 2)))
      else $error("frame clock direction wrong");
   a_proc_port: assert property (w0a |-> ##2 (o_proc_in == $past(i_reg_req.wdata, 2)))
      else $error("processor port wrong");
   c_pin2_out: cover property (w08 && i_reg_req.wdata[5]);
   c_master: cover property (!o_bclk_oe_n && !o_fclk_oe_n);
   c_mute: cover property (o_mute_power_stage);
endmodule // acgc_checker

bind acgc_config_regs acgc_checker u_acgc_checker (.*);

// ===== tb/tb_acgc_config_regs.sv
// Self-checking bench for the configuration register bank.
// Assumes the source model feeds the slave link inputs.
`timescale 1ns/1ps
module tb_acgc_config_regs;
   logic                       i_clk_sys = 1'b0;
   logic                       i_reset_n = 1'b0;
   acgc_pkg::acgc_reg_req_type i_reg_req = '0;
   logic i_pin2_in, i_pin0_in, i_pin2_out, i_pin0_out, i_mute_req, i_bclk_in, i_fclk_in, i_data_in;
   logic o_reg_rvalid, o_pin2_out, o_pin2_oe_n, o_pin0_out, o_pin0_oe_n, o_pin2_sampled, o_pin0_sampled;
   logic o_mute_power_stage, o_bclk_out, o_bclk_oe_n, o_fclk_out, o_fclk_oe_n, o_data_capture, o_data_bit;
   logic o_frame_bit, go = 1'b0, inv = 1'b0;
   logic [7:0] o_reg_rdata, o_proc_in, rnd = 8'h15, pin_rnd = 8'h15, pin_prev = 8'h15;
   logic [7:0] shadow [16];
   logic [3:0] lnk_hist = 4'h0;
   int mismatches = 0, comparisons = 0, pb, pf, n;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] model_rd(input logic [7:0] a);
      return (a inside {8'h08, 8'h09, 8'h0a, 8'h0c}) ? shadow[a[3:0]] : 8'h00;
   endfunction

   assign {i_mute_req, i_pin2_in, i_pin0_in, i_pin2_out, i_pin0_out} = pin_rnd[4:0];
   always #5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      pin_rnd <= lfsr(pin_rnd);
      pin_prev <= pin_rnd;
   end
   // Link levels of the last two edges; a good capture sees no change between them
   always @(posedge i_clk_sys)
      lnk_hist <= {lnk_hist[1:0], i_data_in, i_fclk_in};

   acgc_config_regs u_acgc_config_regs (.*);
   acgc_audio_source u_acgc_audio_source (.i_clk_sys(i_clk_sys), .i_go(go), .i_inv(inv),
      .o_bclk(i_bclk_in), .o_fclk(i_fclk_in), .o_data(i_data_in));

   task automatic report_and_stop;
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_up;
      mismatches++;
      report_and_stop();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge i_clk_sys);
      i_reg_req <= '0;
      if (model_rd(a) !== 8'h00 || a inside {8'h08, 8'h09, 8'h0a, 8'h0c})
         shadow[a[3:0]] = d;
      @(posedge i_clk_sys);
   endtask
   task automatic rd(input logic [7:0] a);
      int k;
      i_reg_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_clk_sys);
      i_reg_req <= '0;
      #1;
      for (k = 0; k < 4 && o_reg_rvalid !== 1'b1; k++)
         @(posedge i_clk_sys) #1;
      if (k == 4)
         give_up();
      check("read data", o_reg_rdata, model_rd(a));
      @(posedge i_clk_sys);
   endtask
   task automatic period(input bit fsel, output int per);
      int k, r, t0;
      logic p, c;
      r = 0;
      t0 = 0;
      p = 1'b1;
      per = 0;
      for (k = 0; k < 3000 && r < 2; k++) begin
         @(posedge i_clk_sys) #1;
         c = fsel ? o_fclk_out : o_bclk_out;
         if (c && !p)
            r++;
         if (c && !p && r == 1)
            t0 = k;
         if (c && !p && r == 2)
            per = k - t0;
         p = c;
      end
      if (r < 2)
         give_up();
   endtask
   task automatic do_reset;
      foreach (shadow[i])
         shadow[i] = 8'h00;
      shadow[12] = 8'h01;
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      @(posedge i_clk_sys) #1;
      check("oe idle", {o_pin2_oe_n, o_pin0_oe_n, o_bclk_oe_n, o_fclk_oe_n}, 4'hf);
      for (int a = 8; a < 13; a++)
         rd(8'(a));
   endtask

   initial begin
      do_reset();
      for (int i = 0; i < 15; i++) begin
         rnd = lfsr(rnd);
         wr(8'h08 + 8'(i % 3), rnd);
         @(posedge i_clk_sys) #1;
         check("direction", {o_pin2_oe_n, o_pin0_oe_n, o_bclk_oe_n, o_fclk_oe_n},
            {~shadow[8][5], ~shadow[8][3], ~shadow[9][4], ~shadow[9][0]});
         check("mute", o_mute_power_stage, pin_prev[4] & shadow[8][4]);
         check("pin sample", {o_pin2_sampled, o_pin0_sampled}, pin_prev[3:2]);
         check("pin drive", {o_pin2_out, o_pin0_out}, pin_prev[1:0]);
         check("proc port", o_proc_in, shadow[10]);
         rd(8'h08 + 8'(i % 3));
      end
      wr(8'h0b, 8'hff);
      rd(8'h0b);
      wr(8'h0c, 8'h03);
      wr(8'h09, 8'h11);
      period(1'b0, pb);
      period(1'b1, pf);
      check("frame period", 16'(pf), 16'(64 * pb));
      for (int pol = 0; pol < 2; pol++) begin
         wr(8'h09, pol ? 8'h20 : 8'h00);
         inv <= pol[0];
         go <= 1'b1;
         @(posedge i_clk_sys);
         go <= 1'b0;
         n = 0;
         repeat (200) begin
            @(posedge i_clk_sys) #1;
            n += int'(o_data_capture === 1'b1);
            if (o_data_capture === 1'b1)
               check("link sample", {o_data_bit, o_frame_bit}, lnk_hist[3:2]);
         end
         check("captures", 16'(n), 16'd16);
      end
      do_reset();
      report_and_stop();
   end
endmodule // tb_acgc_config_regs
